// ### pkg/pva_alarm_regs.vh
// register map and field constants of the process value alarm block
// assumes a 32-bit apb slave with byte addresses, one word per register
`ifndef PVA_ALARM_REGS_VH
`define PVA_ALARM_REGS_VH

// register byte offsets
`define PVA_OFS_CTRL      8'h00
`define PVA_OFS_RANGE_MIN 8'h04
`define PVA_OFS_RANGE_MAX 8'h08
`define PVA_OFS_HYST_PV   8'h0C
`define PVA_OFS_HYST_RATE 8'h10
`define PVA_OFS_ON_DLY    8'h14
`define PVA_OFS_OFF_DLY   8'h18
`define PVA_OFS_SP_BASE   8'h20
`define PVA_OFS_SP_LAST   8'h3C
`define PVA_OFS_ALARM     8'h40
`define PVA_OFS_PV        8'h44
`define PVA_OFS_RATE      8'h48
`define PVA_OFS_IRQ_STAT  8'h4C
`define PVA_OFS_IRQ_CLR   8'h50
`define PVA_OFS_IRQ_EN    8'h54

// control fields
`define PVA_CTRL_RUN      0
`define PVA_CTRL_RATE     1
`define PVA_CTRL_W        2

// reset values
`define PVA_RST_CTRL      2'h3
`define PVA_RST_MIN       16'h0000
`define PVA_RST_MAX       16'h0FA0
`define PVA_RST_WORD      16'h0000
`define PVA_RST_SP_TOP    16'h7FFF
`define PVA_RST_SP_BOT    16'h8000

// alarm level numbering inside each group of four
`define PVA_LVL_PER_GRP   4
`define PVA_LVL_UPPER_N   2
`define PVA_N_LVL         8

`endif

// ### rtl/pva_scale.v
// linear scaling of the raw converted value into the process value,
// plus the rate of change between two successive samples
// assumes raw samples and disconnect state come from same-clock logic
`timescale 1ns/1ps
module pva_scale #(
  parameter W = 16
) (
  // clock, enable, reset
  input  wire         clk,
  input  wire         ce,
  input  wire         srst,
  // upstream sample
  input  wire         smp_vld,
  input  wire [W-1:0] smp_raw,
  input  wire         in_disc,
  input  wire         ovr_high,
  // range, signed; max may lie below min
  input  wire [W-1:0] rng_min,
  input  wire [W-1:0] rng_max,
  // results
  output reg  [W-1:0] pv_r,
  output reg  [W-1:0] rate_r,
  output reg          vld_r
);

  // span is signed, negative for a reversed range (see R9)
  wire signed [W:0]     span = $signed({rng_max[W-1], rng_max}) -
                               $signed({rng_min[W-1], rng_min});
  wire signed [2*W+1:0] prod = span * $signed({1'b0, smp_raw});
  wire signed [W:0]     ofs  = prod[2*W:W];
  wire        [W-1:0]   lin  = rng_min + ofs[W-1:0];
  // disconnect forces the end set by the overrange direction (see R12)
  wire        [W-1:0]   pv_nxt = in_disc ? (ovr_high ? rng_max : rng_min)
                                         : lin;

  // scaled value, rate and a one-cycle update strobe
  always @(posedge clk) begin
    if (srst) begin
      pv_r   <= {W{1'b0}};
      rate_r <= {W{1'b0}};
      vld_r  <= 1'b0;
    end else if (ce) begin
      vld_r <= smp_vld;
      if (smp_vld) begin
        pv_r   <= pv_nxt;
        rate_r <= pv_nxt - pv_r;
      end
    end
  end

endmodule

// ### rtl/pva_level.v
// one alarm level: compare, hysteresis release, on and off delays
// assumes value, set value and hysteresis are signed and same-clock
`timescale 1ns/1ps
module pva_level #(
  parameter W  = 16,
  parameter CW = 16
) (
  // clock, enable, reset
  input  wire          clk,
  input  wire          ce,
  input  wire          srst,
  // configuration
  input  wire          run,
  input  wire          upper,
  input  wire [W-1:0]  val,
  input  wire [W-1:0]  sp,
  input  wire [W-1:0]  hyst,
  input  wire [CW-1:0] on_dly,
  input  wire [CW-1:0] off_dly,
  // result
  output reg           alarm_r
);

  reg  [CW-1:0]       cnt_r;
  wire signed [W+1:0] v  = $signed({{2{val[W-1]}}, val});
  wire signed [W+1:0] s  = $signed({{2{sp[W-1]}}, sp});
  wire signed [W+1:0] h  = $signed({{2{hyst[W-1]}}, hyst});
  // on when above (upper) or below (lower) the live set value (see R4)
  wire on_c  = upper ? (v > s) : (v < s);                      // see R5
  // release uses the current set value, so a moved limit applies (see R1)
  wire off_c = upper ? (v < s - h) : (v > s + h);       // see R2, see R13

  // delay counter runs only while the pending condition holds
  always @(posedge clk) begin
    if (srst) begin
      alarm_r <= 1'b0;
      cnt_r   <= {CW{1'b0}};
    end else if (ce) begin
      if (!run) begin
        // a disabled level drops and forgets its count, frozen with ce
        alarm_r <= 1'b0;
        cnt_r   <= {CW{1'b0}};
      end else if (!alarm_r) begin
        if (!on_c)
          cnt_r <= {CW{1'b0}};                                 // see R7
        else if (cnt_r >= on_dly) begin
          alarm_r <= 1'b1;
          cnt_r   <= {CW{1'b0}};
        end else
          cnt_r <= cnt_r + 1'b1;
      end else begin
        if (!off_c)
          cnt_r <= {CW{1'b0}};                                 // see R8
        else if (cnt_r >= off_dly) begin
          alarm_r <= 1'b0;
          cnt_r   <= {CW{1'b0}};
        end else
          cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule

// ### rtl/pva_alarm.v
// process value alarm block: apb registers, scaling, eight alarm levels
// assumes an apb master on clk and same-clock upstream sample logic
//
// Functional notes
// R1 - raised upper limit releases below new minus hysteresis
// R2 - lowered lower limit releases above new plus hysteresis
// R3 - four set values written independently, unordered
// R4 - upper alarms trip above own set value
// R5 - lower alarms trip below own set value
// R6 - same four levels on value and rate
// R7 - on-delay must elapse with condition held
// R8 - alarm stays until off-delay fully expires
// R9 - reversed scaling range is allowed
// R10 - alarms judge the scaled value only
// R11 - rate alarms are an optional build feature
// R12 - disconnect forces range end by overrange direction
// R13 - release at set value minus or plus hysteresis
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "pva_alarm_regs.vh"
module pva_alarm #(
  parameter W       = 16,
  parameter CW      = 16,
  parameter RATE_EN = 1
) (
  // clock, enable, reset
  input  wire          clk,
  input  wire          ce,
  input  wire          srst,
  // apb slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  // upstream converted sample
  input  wire          smp_vld,
  input  wire [W-1:0]  smp_raw,
  input  wire          in_disc,
  input  wire          ovr_high,
  // alarm outputs and interrupt
  output reg  [7:0]    alarm_out,
  output reg           irq
);

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg  [`PVA_CTRL_W-1:0] ctrl_r;
  reg  [W-1:0]           rng_min_r;
  reg  [W-1:0]           rng_max_r;
  reg  [W-1:0]           hyst_pv_r;
  reg  [W-1:0]           hyst_rt_r;
  reg  [CW-1:0]          on_dly_r;
  reg  [CW-1:0]          off_dly_r;
  reg  [W-1:0]           sp_r [0:`PVA_N_LVL-1];
  reg  [7:0]             irq_stat_r;
  reg  [7:0]             irq_en_r;
  reg  [7:0]             alarm_d_r;

  wire [W-1:0]           pv;
  wire [W-1:0]           rate;
  wire                   pv_vld;
  wire [7:0]             lvl_alarm;

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  wire       setup   = psel && !penable;
  wire       acc     = psel && penable && pready;
  wire       wr      = acc && pwrite;
  wire       is_sp   = (paddr >= `PVA_OFS_SP_BASE) &&
                       (paddr <= `PVA_OFS_SP_LAST);
  wire [2:0] sp_idx  = paddr[4:2];
  wire       aligned = (paddr[1:0] == 2'b00);

  // mapped check for the access now in setup
  reg        hit;
  always @* begin
    hit = 1'b1;
    case (paddr)
      `PVA_OFS_CTRL,
      `PVA_OFS_RANGE_MIN,
      `PVA_OFS_RANGE_MAX,
      `PVA_OFS_HYST_PV,
      `PVA_OFS_HYST_RATE,
      `PVA_OFS_ON_DLY,
      `PVA_OFS_OFF_DLY,
      `PVA_OFS_ALARM,
      `PVA_OFS_PV,
      `PVA_OFS_RATE,
      `PVA_OFS_IRQ_STAT,
      `PVA_OFS_IRQ_CLR,
      `PVA_OFS_IRQ_EN: hit = 1'b1;
      default:         hit = is_sp && aligned;
    endcase
  end

  // read mux, sign-extended where the field is signed, except the two hysteresis words
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      `PVA_OFS_CTRL:      rd_nxt = {{(32-`PVA_CTRL_W){1'b0}}, ctrl_r};
      `PVA_OFS_RANGE_MIN: rd_nxt = {{(32-W){rng_min_r[W-1]}}, rng_min_r};
      `PVA_OFS_RANGE_MAX: rd_nxt = {{(32-W){rng_max_r[W-1]}}, rng_max_r};
      `PVA_OFS_HYST_PV:   rd_nxt = {{(32-W){1'b0}}, hyst_pv_r};
      `PVA_OFS_HYST_RATE: rd_nxt = {{(32-W){1'b0}}, hyst_rt_r};
      `PVA_OFS_ON_DLY:    rd_nxt = {{(32-CW){1'b0}}, on_dly_r};
      `PVA_OFS_OFF_DLY:   rd_nxt = {{(32-CW){1'b0}}, off_dly_r};
      `PVA_OFS_ALARM:     rd_nxt = {24'h00_0000, lvl_alarm};
      `PVA_OFS_PV:        rd_nxt = {{(32-W){pv[W-1]}}, pv};
      `PVA_OFS_RATE:      rd_nxt = {{(32-W){rate[W-1]}}, rate};
      `PVA_OFS_IRQ_STAT:  rd_nxt = {24'h00_0000, irq_stat_r};
      `PVA_OFS_IRQ_EN:    rd_nxt = {24'h00_0000, irq_en_r};
      default: begin
        if (is_sp && aligned)
          rd_nxt = {{(32-W){sp_r[sp_idx][W-1]}}, sp_r[sp_idx]};
      end
    endcase
  end

  // no wait state: ready and data are loaded in the setup cycle
  always @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      if (setup) begin
        pready  <= 1'b1;
        pslverr <= !hit;
        prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration writes

  integer i;
  always @(posedge clk) begin
    if (srst) begin
      ctrl_r    <= `PVA_RST_CTRL;
      rng_min_r <= `PVA_RST_MIN;
      rng_max_r <= `PVA_RST_MAX;
      hyst_pv_r <= `PVA_RST_WORD;
      hyst_rt_r <= `PVA_RST_WORD;
      on_dly_r  <= `PVA_RST_WORD;
      off_dly_r <= `PVA_RST_WORD;
      irq_en_r  <= 8'h00;
      for (i = 0; i < `PVA_N_LVL; i = i + 1) begin
        if ((i % `PVA_LVL_PER_GRP) < `PVA_LVL_UPPER_N)
          sp_r[i] <= `PVA_RST_SP_TOP;
        else
          sp_r[i] <= `PVA_RST_SP_BOT;
      end
    end else if (ce && wr && !pslverr) begin
      case (paddr)
        `PVA_OFS_CTRL:      ctrl_r    <= pwdata[`PVA_CTRL_W-1:0];
        // min above max is legal and reverses the range (see R9)
        `PVA_OFS_RANGE_MIN: rng_min_r <= pwdata[W-1:0];
        `PVA_OFS_RANGE_MAX: rng_max_r <= pwdata[W-1:0];
        `PVA_OFS_HYST_PV:   hyst_pv_r <= pwdata[W-1:0];
        `PVA_OFS_HYST_RATE: hyst_rt_r <= pwdata[W-1:0];
        `PVA_OFS_ON_DLY:    on_dly_r  <= pwdata[CW-1:0];
        `PVA_OFS_OFF_DLY:   off_dly_r <= pwdata[CW-1:0];
        `PVA_OFS_IRQ_EN:    irq_en_r  <= pwdata[7:0];
        default: begin
          // each set value stands alone, no ordering check (see R3)
          if (is_sp)
            sp_r[sp_idx] <= pwdata[W-1:0];
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // scaling and rate

  pva_scale #(
    .W        (W)
  ) u_scale (
    .clk      (clk),
    .ce       (ce),
    .srst     (srst),
    .smp_vld  (smp_vld),
    .smp_raw  (smp_raw),
    .in_disc  (in_disc),
    .ovr_high (ovr_high),
    .rng_min  (rng_min_r),
    .rng_max  (rng_max_r),
    .pv_r     (pv),
    .rate_r   (rate),
    .vld_r    (pv_vld)
  );

  ////////////////////////////////////////////////////////////////////////
  // alarm levels: 0..3 on the value, 4..7 on the rate

  genvar g;
  generate
    for (g = 0; g < `PVA_N_LVL; g = g + 1) begin : lvl
      localparam RT = (g >= `PVA_LVL_PER_GRP);
      localparam UP = ((g % `PVA_LVL_PER_GRP) < `PVA_LVL_UPPER_N);
      if (RT && RATE_EN == 0) begin : none
        // variant without rate alarms (see R11)
        assign lvl_alarm[g] = 1'b0;
      end else begin : inst
        wire run = ctrl_r[`PVA_CTRL_RUN] &&
                   (!RT || ctrl_r[`PVA_CTRL_RATE]);
        // scaled value drives the compare, not the raw input (see R10)
        // identical level logic serves value and rate (see R6)
        pva_level #(
          .W       (W),
          .CW      (CW)
        ) u_lvl (
          .clk     (clk),
          .ce      (ce),
          .srst    (srst),
          .run     (run),
          .upper   (UP[0]),
          .val     (RT ? rate : pv),
          .sp      (sp_r[g]),
          .hyst    (RT ? hyst_rt_r : hyst_pv_r),
          .on_dly  (on_dly_r),
          .off_dly (off_dly_r),
          .alarm_r (lvl_alarm[g])
        );
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // interrupt: sticky on alarm rise, set wins over clear

  wire       clr_wr = wr && !pslverr && (paddr == `PVA_OFS_IRQ_CLR);
  wire [7:0] rise   = lvl_alarm & ~alarm_d_r;
  wire [7:0] clr    = clr_wr ? pwdata[7:0] : 8'h00;

  always @(posedge clk) begin
    if (srst) begin
      alarm_d_r  <= 8'h00;
      irq_stat_r <= 8'h00;
      alarm_out  <= 8'h00;
      irq        <= 1'b0;
    end else if (ce) begin
      alarm_d_r  <= lvl_alarm;
      irq_stat_r <= (irq_stat_r & ~clr) | rise;
      alarm_out  <= lvl_alarm;
      irq        <= |(((irq_stat_r & ~clr) | rise) & irq_en_r);
    end
  end

endmodule

// ### verification/pva_alarm_asserts.sv
// bus handshake and reset checks of the alarm block
// assumes one clock domain, bound to pva_alarm
`timescale 1ns/1ps
module pva_chk #(
  parameter RATE_EN = 1
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        ce,
  input wire logic        srst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // results
  input wire logic [7:0]  alarm_out,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // setup cycle, then its answer
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_answer;
    pready && psel && penable;
  endsequence
  a_ready_next: assert property (s_setup |=> s_answer)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready && ce |=> !pready)
    else $error("ready held too long");
  a_ready_idle: assert property (!psel |-> !pready)
    else $error("ready while idle");
  a_err_align: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned address accepted");
  a_err_zero: assert property (pready && pslverr && !pwrite
    |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  a_ctrl_ok: assert property (pready && paddr == 8'h00 |-> !pslverr)
    else $error("control register refused");
  a_read_hold: assert property ($fell(pready) |-> $stable(prdata))
    else $error("read data moved");
  a_reset_quiet: assert property ($fell(srst) |-> alarm_out == 8'h00 && !irq)
    else $error("outputs active after reset");
  // set value words are always mapped, in any order
  sequence s_sp_acc;
    pready && paddr >= 8'h20 && paddr <= 8'h3C && paddr[1:0] == 2'h0;
  endsequence
  a_sp_taken: assert property (s_sp_acc |-> !pslverr)
    else $error("set value access refused");
  a_no_rate: assert property (RATE_EN == 0 |-> alarm_out < 8'h10)
    else $error("rate level active in variant without rate");
endmodule
////////////////////////////////////////////////////////////
bind pva_alarm pva_chk #(.RATE_EN(RATE_EN)) u_chk (
  .clk(clk), .ce(ce), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .alarm_out(alarm_out), .irq(irq));

// ### verification/pva_host.sv
// bus master standing in for the host controller
// assumes the slave answers by pready at a rising edge
`timescale 1ns/1ps
module pva_host (
  // clock
  input  wire logic        clk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end
  // one transfer; released address and write data show the inverse of their last value, pwrite holds
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~wd;
  endtask
endmodule

// ### verification/tb.sv
// self-checking bench of the alarm block against a behavioural model
// assumes pva_host as bus master and the register header on the path
`timescale 1ns/1ps
`include "pva_alarm_regs.vh"
module tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        smp_vld = 1'b0;
  logic [15:0] smp_raw = 16'h0000;
  logic        in_disc = 1'b0;
  logic        ovr_high = 1'b0;
  logic        ce = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, irq, rd_e;
  logic [7:0]  paddr, alarm_out, alarm_nr;
  logic [7:0]  st_m = 8'h00;
  logic [7:0]  stat_m = 8'h00;
  logic [31:0] pwdata, prdata, rd_d;
  int          n_errors, n_tests, cyc, pv_m, rt_m, prv;
  int          sp_m [8] = '{32767, 32767, -32768, -32768,
                            32767, 32767, -32768, -32768};
  int          ra [14] = '{0, 3, 8, 4000, 'h24, 32767, 'h21, 0,
                           'h2C, -32768, 'h54, 0, 'h7C, 0};
  int          cfg [12] = '{4, 4000, 8, 0, 12, 100, 20, 3, 24, 3, 84, 2};
  int          stp [52] = '{0, 2500, 5, 3000, 6, 1000, 9, 200, 0, 3200,
    0, 2950, 1, 2800, 0, 2950, 0, 2800, 1, 3200, 0, 2950, 0, 3300,
    5, 3500, 0, 3450, 0, 3350, 0, 800, 6, 500, 0, 550, 0, 650,
    4, 500, 0, 800, 2, 1, 2, 0, 3, 0, 3, 0, 3, 0};
  // device and host
  pva_alarm u_dut (
    .clk(clk), .ce(ce), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .smp_vld(smp_vld),
    .smp_raw(smp_raw), .in_disc(in_disc), .ovr_high(ovr_high),
    .alarm_out(alarm_out), .irq(irq));
  // variant built without rate levels, on the same bus and samples
  pva_alarm #(.RATE_EN(0)) u_nort (
    .clk(clk), .ce(ce), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .smp_vld(smp_vld), .smp_raw(smp_raw),
    .in_disc(in_disc), .ovr_high(ovr_high), .alarm_out(alarm_nr),
    .irq());
  pva_host u_host (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // 250 mhz clock
  always #2 clk = ~clk;
  // run-time ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      finish_test();
    end
  end
  task finish_test;
    $display("Checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // compare one value and count it
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    u_host.xfer(1'b1, a, v, rd_d, rd_e);
  endtask
  task rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0000_0000, rd_d, rd_e);
  endtask
  // set value write or sample, then settle, model and compare (mode 1 samples only)
  task step(input int md, input int t);
    int raw, v, h;
    logic up, onc, offc;
    if (md >= 4) begin
      wr(8'h20 + 8'(4 * (md - 4)), t);
      sp_m[md-4] = t;
    end else begin
      if (md == 3)
        raw = $urandom_range(65535);
      else
        raw = (4000 - t) * 65536 / 4000;
      @(posedge clk);
      smp_vld  <= 1'b1;
      smp_raw  <= raw[15:0];
      in_disc  <= (md == 2);
      ovr_high <= t[0];
      @(posedge clk);
      smp_vld <= 1'b0;
      pv_m = (md == 2) ? (t ? 0 : 4000) : 4000 + ((-4000 * raw) >>> 16);
      rt_m = pv_m - prv;
      prv = pv_m;
      if (md == 1)
        return;
    end
    repeat (12) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      up = k % 4 < 2;
      v = k < 4 ? pv_m : rt_m;
      h = k < 4 ? 100 : 0;
      onc = up ? v > sp_m[k] : v < sp_m[k];
      offc = up ? v < sp_m[k] - h : v > sp_m[k] + h;
      if (onc && !st_m[k])
        stat_m[k] = 1'b1;
      if (onc)
        st_m[k] = 1'b1;
      else if (offc)
        st_m[k] = 1'b0;
    end
    rd(`PVA_OFS_PV);
    chk("pv", pv_m, rd_d); // scaled value
    rd(`PVA_OFS_RATE);
    chk("rate", rt_m, rd_d); // difference
    chk("alarm", st_m, alarm_out); // levels
    chk("norate", {4'h0, st_m[3:0]}, alarm_nr); // value only
    rd(`PVA_OFS_IRQ_STAT);
    chk("status", stat_m, rd_d); // no early rise
    chk("irq", |(stat_m & 8'h02), irq);
    wr(`PVA_OFS_IRQ_CLR, 32'h0000_00FF);
    stat_m = 8'h00;
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h0f84));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 14; i += 2) begin
      rd(ra[i][7:0]);
      chk("reset", ra[i+1], rd_d);
      chk("refused", ra[i][1:0] != 0 || ra[i] == 'h7C, rd_e);
    end
    for (int i = 0; i < 12; i += 2)
      wr(cfg[i][7:0], cfg[i+1]); // reversed range
    rd(`PVA_OFS_PV);
    prv = $signed(rd_d);
    for (int i = 0; i < 52; i += 2)
      step(stp[i], stp[i+1]);
    // rate enable cleared: rate levels drop, value levels stay
    wr(`PVA_OFS_CTRL, 32'h0000_0001);
    st_m[7:4] = 4'h0;
    repeat (4) @(posedge clk);
    chk("rate off", st_m, alarm_out);
    // a sample offered while ce is low must be lost
    @(posedge clk);
    ce      <= 1'b0;
    smp_vld <= 1'b1;
    smp_raw <= 16'($urandom);
    @(posedge clk);
    ce      <= 1'b1;
    smp_vld <= 1'b0;
    rd(`PVA_OFS_PV);
    chk("frozen", pv_m, rd_d); // value held
    finish_test();
  end
endmodule
